// *** hw/pit_pkg.sv ***
// Constants shared by both ends of the priority interrupt timer link.
// Assumes a 16-bit register port and a single 20 MHz system clock.
package pit_pkg;
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // Register addresses
   localparam logic [15:0] ADDR_TIMER_START = 16'hF030;
   localparam logic [15:0] ADDR_TIMER_CONTROL = 16'hF040;
   localparam logic [15:0] ADDR_OPERATING_MODE = 16'hF041;
   localparam logic [15:0] ADDR_INTERRUPT_ENABLE = 16'hF044;
   localparam logic [15:0] ADDR_STATUS_FLAGS = 16'hF045;
   localparam logic [15:0] ADDR_COUNTER = 16'hF046;
   localparam logic [15:0] ADDR_COMPARE_A = 16'hF048;
   localparam logic [15:0] ADDR_PRIORITY_A = 16'hF080;
   localparam logic [15:0] ADDR_PRIORITY_C = 16'hF082;
   localparam logic [15:0] ADDR_PIN_FUNCTION = 16'hFFCA;
   localparam logic [15:0] ADDR_EDGE_SELECT = 16'hFFF2;
   localparam logic [15:0] ADDR_REQUEST_ENABLE = 16'hFFF3;
   localparam logic [15:0] ADDR_MASK_LEVEL = 16'hFFF5;
   localparam logic [15:0] ADDR_REQUEST_FLAGS = 16'hFFF6;
   // Field positions
   localparam int COUNTER_RUN_BIT = 1;
   localparam int CLEAR_SEL_HI = 6;
   localparam int CLEAR_SEL_LO = 5;
   localparam int EDGE_SEL_HI = 4;
   localparam int EDGE_SEL_LO = 3;
   localparam int PRESCALE_HI = 2;
   localparam int PRIO_HI = 7;
   localparam int PRIO_LO = 6;
   localparam int FLAG_BIT = 0;
   // Field encodings
   localparam logic [1:0] CLEAR_ON_MATCH_A = 2'h1;
   localparam logic [1:0] EDGE_RISING = 2'h0;
   localparam logic [1:0] EDGE_FALLING = 2'h1;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [2:0] PRESCALE_DIV4 = 3'h1;
   localparam logic [2:0] PRESCALE_DIV16 = 3'h2;
   localparam logic [2:0] PRESCALE_DIV64 = 3'h3;
   localparam logic [2:0] PRESCALE_DIV256 = 3'h6;
   localparam logic [2:0] PRESCALE_DIV1024 = 3'h7;
   localparam int PRESCALE_W = 10;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_COMPARE_A = 16'hFFFF;
   localparam logic CORE_DISABLE_RESET = 1'b1;
   // Request sources
   localparam logic SRC_PIN = 1'b0;
   localparam logic SRC_TIMER = 1'b1;
endpackage : pit_pkg

// *** hw/pit_link_if.sv ***
// Link between the interrupt/timer block and the processor core end.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface pit_link_if;
   // Register port, driven by the core end except reg_rdata
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   // Prioritised request, driven by the device end
   logic irq_valid;
   logic [1:0] irq_level;
   logic irq_source;

   // Interrupt and timer block
   modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd, output reg_rdata, irq_valid, irq_level, irq_source);
   // Processor core end
   modport core (output reg_addr, reg_wdata, reg_wr, reg_rd, input reg_rdata, irq_valid, irq_level, irq_source);
endinterface : pit_link_if

// *** hw/pit_device.sv ***
// Priority interrupt controller with one compare-match timer channel.
// Assumes an active-low request pin synchronous to the system clock.
`timescale 1ns/100ps
module pit_device #(
   parameter int PRESCALE_W = pit_pkg::PRESCALE_W
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Link to the core
   pit_link_if.dev link,
   // Shared pin, active low
   input wire logic external_request_pin_n_i,
   // Compare match pulse
   output logic compare_match_o
);
   // Register state
   logic counter_run_bit_ff, nxt_counter_run_bit;
   logic [7:0] timer_control_ff, nxt_timer_control;
   logic [1:0] operating_mode_ff, nxt_operating_mode;
   logic compare_interrupt_enable_a_ff, nxt_compare_interrupt_enable_a;
   logic compare_flag_a_ff, nxt_compare_flag_a;
   logic flag_read_armed_ff, nxt_flag_read_armed;
   logic [15:0] general_register_a_ff, nxt_general_register_a;
   logic [15:0] channel_counter_ff, nxt_channel_counter;
   logic [7:0] priority_a_ff, nxt_priority_a;
   logic [7:0] priority_c_ff, nxt_priority_c;
   logic pin_function_ff, nxt_pin_function;
   logic pin_edge_select_bit_ff, nxt_pin_edge_select_bit;
   logic pin_request_enable_bit_ff, nxt_pin_request_enable_bit;
   logic [7:0] mask_level_ff, nxt_mask_level;
   logic pin_request_flag_ff, nxt_pin_request_flag;
   // Pin history and prescaler
   logic pin_prev_ff, nxt_pin_prev;
   logic [PRESCALE_W-1:0] prescale_ff, nxt_prescale;
   // Outputs
   logic [15:0] rdata_ff, nxt_rdata;
   logic irq_valid_ff, nxt_irq_valid;
   logic [1:0] irq_level_ff, nxt_irq_level;
   logic irq_source_ff, nxt_irq_source;
   logic match_ff, nxt_match;

   // Two-bit priority field to level
   function automatic logic [1:0] prio_level(input logic [7:0] bank);
      if (bank[pit_pkg::PRIO_HI]) begin
         prio_level = 2'h2;
      end else if (bank[pit_pkg::PRIO_LO]) begin
         prio_level = 2'h1;
      end else begin
         prio_level = 2'h0;
      end
   endfunction : prio_level

   // Prescaler tap for a divider select
   function automatic int tap_bit(input logic [2:0] sel);
      case (sel)
         pit_pkg::PRESCALE_DIV4: tap_bit = 1;
         pit_pkg::PRESCALE_DIV16: tap_bit = 3;
         pit_pkg::PRESCALE_DIV64: tap_bit = 5;
         pit_pkg::PRESCALE_DIV256: tap_bit = 7;
         pit_pkg::PRESCALE_DIV1024: tap_bit = 9;
         default: tap_bit = -1;
      endcase
   endfunction : tap_bit

   // Decode helpers
   logic wr_en, rd_en;
   logic [1:0] pin_level, timer_level, clear_sel, edge_sel;
   logic pin_edge, count_tick, tap_rise, tap_fall, match_a;
   logic pin_req, timer_req;
   int tap;

   // Next-state logic for all registers
   always_comb begin
      wr_en = link.reg_wr;
      rd_en = link.reg_rd;
      nxt_counter_run_bit = counter_run_bit_ff;
      nxt_timer_control = timer_control_ff;
      nxt_operating_mode = operating_mode_ff;
      nxt_compare_interrupt_enable_a = compare_interrupt_enable_a_ff;
      nxt_general_register_a = general_register_a_ff;
      nxt_priority_a = priority_a_ff;
      nxt_priority_c = priority_c_ff;
      nxt_pin_function = pin_function_ff;
      nxt_pin_edge_select_bit = pin_edge_select_bit_ff;
      nxt_pin_request_enable_bit = pin_request_enable_bit_ff;
      nxt_mask_level = mask_level_ff;
      nxt_pin_prev = external_request_pin_n_i;
      nxt_prescale = prescale_ff + 1'b1;
      clear_sel = timer_control_ff[pit_pkg::CLEAR_SEL_HI:pit_pkg::CLEAR_SEL_LO];
      edge_sel = timer_control_ff[pit_pkg::EDGE_SEL_HI:pit_pkg::EDGE_SEL_LO];
      tap = tap_bit(timer_control_ff[pit_pkg::PRESCALE_HI:0]);
      // Edges of the divided clock
      if (tap < 0) begin
         tap_rise = 1'b1;
         tap_fall = 1'b1;
      end else begin
         tap_rise = !prescale_ff[tap] && nxt_prescale[tap];
         tap_fall = prescale_ff[tap] && !nxt_prescale[tap];
      end
      // Input clock edge choice
      case (edge_sel)
         pit_pkg::EDGE_RISING: count_tick = tap_rise;
         pit_pkg::EDGE_FALLING: count_tick = tap_fall;
         default: count_tick = tap_rise || tap_fall;
      endcase
      // Count only while running in normal mode
      count_tick = count_tick && counter_run_bit_ff && (operating_mode_ff == pit_pkg::MODE_NORMAL);
      match_a = count_tick && (channel_counter_ff == general_register_a_ff);
      nxt_match = match_a;
      nxt_channel_counter = channel_counter_ff;
      if (match_a && clear_sel == pit_pkg::CLEAR_ON_MATCH_A) begin
         nxt_channel_counter = '0;
      end else if (count_tick) begin
         nxt_channel_counter = channel_counter_ff + 1'b1;
      end
      // Pin edge, only when the pin is routed here
      if (pin_edge_select_bit_ff) begin
         pin_edge = !pin_prev_ff && external_request_pin_n_i;
      end else begin
         pin_edge = pin_prev_ff && !external_request_pin_n_i;
      end
      pin_edge = pin_edge && pin_function_ff;
      // Flag A: read-then-write-0 clear, set wins
      nxt_compare_flag_a = compare_flag_a_ff;
      nxt_flag_read_armed = flag_read_armed_ff;
      if (rd_en && link.reg_addr == pit_pkg::ADDR_STATUS_FLAGS && compare_flag_a_ff) begin
         nxt_flag_read_armed = 1'b1;
      end
      if (wr_en && link.reg_addr == pit_pkg::ADDR_STATUS_FLAGS) begin
         if (!link.reg_wdata[pit_pkg::FLAG_BIT] && flag_read_armed_ff) begin
            nxt_compare_flag_a = 1'b0;
         end
         nxt_flag_read_armed = 1'b0;
      end
      if (match_a) begin
         nxt_compare_flag_a = 1'b1;
      end
      // Pin flag: write 0 clears, set wins
      nxt_pin_request_flag = pin_request_flag_ff;
      if (wr_en && link.reg_addr == pit_pkg::ADDR_REQUEST_FLAGS && !link.reg_wdata[pit_pkg::FLAG_BIT]) begin
         nxt_pin_request_flag = 1'b0;
      end
      if (pin_edge) begin
         nxt_pin_request_flag = 1'b1;
      end
      // Register writes; only compare A takes all sixteen bits
      if (wr_en) begin
         case (link.reg_addr)
            pit_pkg::ADDR_TIMER_START: nxt_counter_run_bit = link.reg_wdata[pit_pkg::COUNTER_RUN_BIT];
            pit_pkg::ADDR_TIMER_CONTROL: nxt_timer_control = link.reg_wdata[7:0];
            pit_pkg::ADDR_OPERATING_MODE: nxt_operating_mode = link.reg_wdata[1:0];
            pit_pkg::ADDR_INTERRUPT_ENABLE: nxt_compare_interrupt_enable_a = link.reg_wdata[0];
            pit_pkg::ADDR_COMPARE_A: nxt_general_register_a = link.reg_wdata;
            pit_pkg::ADDR_PRIORITY_A: nxt_priority_a = link.reg_wdata[7:0];
            pit_pkg::ADDR_PRIORITY_C: nxt_priority_c = link.reg_wdata[7:0];
            pit_pkg::ADDR_PIN_FUNCTION: nxt_pin_function = link.reg_wdata[0];
            pit_pkg::ADDR_EDGE_SELECT: nxt_pin_edge_select_bit = link.reg_wdata[0];
            pit_pkg::ADDR_REQUEST_ENABLE: nxt_pin_request_enable_bit = link.reg_wdata[0];
            pit_pkg::ADDR_MASK_LEVEL: nxt_mask_level = link.reg_wdata[7:0];
            default: ;
         endcase
      end
      // Read data, zero for unmapped addresses
      nxt_rdata = '0;
      if (rd_en) begin
         case (link.reg_addr)
            pit_pkg::ADDR_TIMER_START: nxt_rdata[pit_pkg::COUNTER_RUN_BIT] = counter_run_bit_ff;
            pit_pkg::ADDR_TIMER_CONTROL: nxt_rdata[7:0] = timer_control_ff;
            pit_pkg::ADDR_OPERATING_MODE: nxt_rdata[1:0] = operating_mode_ff;
            pit_pkg::ADDR_INTERRUPT_ENABLE: nxt_rdata[0] = compare_interrupt_enable_a_ff;
            pit_pkg::ADDR_STATUS_FLAGS: nxt_rdata[0] = compare_flag_a_ff;
            pit_pkg::ADDR_COUNTER: nxt_rdata = channel_counter_ff;
            pit_pkg::ADDR_COMPARE_A: nxt_rdata = general_register_a_ff;
            pit_pkg::ADDR_PRIORITY_A: nxt_rdata[7:0] = priority_a_ff;
            pit_pkg::ADDR_PRIORITY_C: nxt_rdata[7:0] = priority_c_ff;
            pit_pkg::ADDR_PIN_FUNCTION: nxt_rdata[0] = pin_function_ff;
            pit_pkg::ADDR_EDGE_SELECT: nxt_rdata[0] = pin_edge_select_bit_ff;
            pit_pkg::ADDR_REQUEST_ENABLE: nxt_rdata[0] = pin_request_enable_bit_ff;
            pit_pkg::ADDR_MASK_LEVEL: nxt_rdata[7:0] = mask_level_ff;
            pit_pkg::ADDR_REQUEST_FLAGS: nxt_rdata[0] = pin_request_flag_ff;
            default: nxt_rdata = '0;
         endcase
      end
      // Per-source requests gated by enable and mask
      pin_level = prio_level(priority_a_ff);
      timer_level = prio_level(priority_c_ff);
      pin_req = pin_request_flag_ff && pin_request_enable_bit_ff && !mask_level_ff[pin_level];
      timer_req = compare_flag_a_ff && compare_interrupt_enable_a_ff && !mask_level_ff[timer_level];
      // Highest level wins, pin on a tie
      nxt_irq_valid = pin_req || timer_req;
      if (pin_req && (!timer_req || pin_level >= timer_level)) begin
         nxt_irq_level = pin_level;
         nxt_irq_source = pit_pkg::SRC_PIN;
      end else if (timer_req) begin
         nxt_irq_level = timer_level;
         nxt_irq_source = pit_pkg::SRC_TIMER;
      end else begin
         nxt_irq_level = 2'h0;
         nxt_irq_source = pit_pkg::SRC_PIN;
      end
   end

   // Register stage
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         counter_run_bit_ff <= 1'b0;
         timer_control_ff <= pit_pkg::RESET_BYTE;
         operating_mode_ff <= 2'h0;
         compare_interrupt_enable_a_ff <= 1'b0;
         compare_flag_a_ff <= 1'b0;
         flag_read_armed_ff <= 1'b0;
         general_register_a_ff <= pit_pkg::RESET_COMPARE_A;
         channel_counter_ff <= '0;
         priority_a_ff <= pit_pkg::RESET_BYTE;
         priority_c_ff <= pit_pkg::RESET_BYTE;
         pin_function_ff <= 1'b0;
         pin_edge_select_bit_ff <= 1'b0;
         pin_request_enable_bit_ff <= 1'b0;
         mask_level_ff <= pit_pkg::RESET_BYTE;
         pin_request_flag_ff <= 1'b0;
         pin_prev_ff <= 1'b1;
         prescale_ff <= '0;
         rdata_ff <= '0;
         irq_valid_ff <= 1'b0;
         irq_level_ff <= 2'h0;
         irq_source_ff <= 1'b0;
         match_ff <= 1'b0;
      end else begin
         counter_run_bit_ff <= nxt_counter_run_bit;
         timer_control_ff <= nxt_timer_control;
         operating_mode_ff <= nxt_operating_mode;
         compare_interrupt_enable_a_ff <= nxt_compare_interrupt_enable_a;
         compare_flag_a_ff <= nxt_compare_flag_a;
         flag_read_armed_ff <= nxt_flag_read_armed;
         general_register_a_ff <= nxt_general_register_a;
         channel_counter_ff <= nxt_channel_counter;
         priority_a_ff <= nxt_priority_a;
         priority_c_ff <= nxt_priority_c;
         pin_function_ff <= nxt_pin_function;
         pin_edge_select_bit_ff <= nxt_pin_edge_select_bit;
         pin_request_enable_bit_ff <= nxt_pin_request_enable_bit;
         mask_level_ff <= nxt_mask_level;
         pin_request_flag_ff <= nxt_pin_request_flag;
         pin_prev_ff <= nxt_pin_prev;
         prescale_ff <= nxt_prescale;
         rdata_ff <= nxt_rdata;
         irq_valid_ff <= nxt_irq_valid;
         irq_level_ff <= nxt_irq_level;
         irq_source_ff <= nxt_irq_source;
         match_ff <= nxt_match;
      end
   end

   // Drive the link and the pulse output
   assign link.reg_rdata = rdata_ff;
   assign link.irq_valid = irq_valid_ff;
   assign link.irq_level = irq_level_ff;
   assign link.irq_source = irq_source_ff;
   assign compare_match_o = match_ff;
endmodule : pit_device

// *** hw/pit_core.sv ***
// Processor core end: forwards software register access and accepts
// prioritised requests under a global disable bit. Assumes one clock.
`timescale 1ns/100ps
module pit_core #(
   parameter int DEPTH_W = 3
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Link to the device
   pit_link_if.core link,
   // Software register port
   input wire logic [15:0] sw_addr_i,
   input wire logic [15:0] sw_wdata_i,
   input wire logic sw_wr_i,
   input wire logic sw_rd_i,
   output logic [15:0] sw_rdata_o,
   // Condition code disable bit control
   input wire logic disable_clear_i,
   input wire logic disable_set_i,
   input wire logic handler_return_i,
   // Acceptance report
   output logic accept_o,
   output logic [1:0] accept_level_o,
   output logic accept_source_o,
   output logic disable_bit_o,
   output logic [DEPTH_W-1:0] nest_depth_o
);
   // Core state
   logic disable_bit_ff, nxt_disable_bit;
   logic [DEPTH_W-1:0] depth_ff, nxt_depth;
   logic accept_ff, nxt_accept;
   logic [1:0] level_ff, nxt_level;
   logic source_ff, nxt_source;
   logic take;

   // Register port passes straight through
   assign link.reg_addr = sw_addr_i;
   assign link.reg_wdata = sw_wdata_i;
   assign link.reg_wr = sw_wr_i;
   assign link.reg_rd = sw_rd_i;
   assign sw_rdata_o = link.reg_rdata;

   // Acceptance and disable bit bookkeeping
   always_comb begin
      take = link.irq_valid && !disable_bit_ff && !accept_ff;
      nxt_disable_bit = disable_bit_ff;
      nxt_depth = depth_ff;
      nxt_accept = take;
      nxt_level = take ? link.irq_level : level_ff;
      nxt_source = take ? link.irq_source : source_ff;
      if (handler_return_i && depth_ff != '0) begin
         nxt_depth = depth_ff - 1'b1;
         nxt_disable_bit = 1'b0;
      end else if (disable_clear_i) begin
         nxt_disable_bit = 1'b0;
      end else if (disable_set_i) begin
         nxt_disable_bit = 1'b1;
      end
      // Entry sets disable; nesting needs the handler to clear it
      if (take) begin
         nxt_disable_bit = 1'b1;
         nxt_depth = depth_ff + 1'b1;
      end
   end

   // Register stage
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         disable_bit_ff <= pit_pkg::CORE_DISABLE_RESET;
         depth_ff <= '0;
         accept_ff <= 1'b0;
         level_ff <= 2'h0;
         source_ff <= 1'b0;
      end else begin
         disable_bit_ff <= nxt_disable_bit;
         depth_ff <= nxt_depth;
         accept_ff <= nxt_accept;
         level_ff <= nxt_level;
         source_ff <= nxt_source;
      end
   end

   // Outputs from flops
   assign accept_o = accept_ff;
   assign accept_level_o = level_ff;
   assign accept_source_o = source_ff;
   assign disable_bit_o = disable_bit_ff;
   assign nest_depth_o = depth_ff;
endmodule : pit_core

// *** test/pit_link_monitor.sv ***
// Concurrent checks on the link between device and core ends.
// Assumes one clock; sees only the link signals.
`timescale 1ns/100ps
module pit_link_monitor (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Request link
   input wire logic irq_valid,
   input wire logic [1:0] irq_level,
   input wire logic irq_source
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   logic [2:0] mask_sh_ff; // Shadow of mask bits
   logic [1:0] pri_a_sh_ff; // Shadow of pin priority
   logic [1:0] pri_c_sh_ff; // Shadow of timer priority
   // Follow register writes as the device takes them
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_sh_ff <= 3'h0;
         pri_a_sh_ff <= 2'h0;
         pri_c_sh_ff <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == pit_pkg::ADDR_MASK_LEVEL) mask_sh_ff <= reg_wdata[2:0];
         if (reg_addr == pit_pkg::ADDR_PRIORITY_A) pri_a_sh_ff <= reg_wdata[7:6];
         if (reg_addr == pit_pkg::ADDR_PRIORITY_C) pri_c_sh_ff <= reg_wdata[7:6];
      end
   end
   // Level of a two-bit priority field
   function automatic logic [1:0] lvl(input logic [1:0] p);
      return p[1] ? 2'h2 : {1'b0, p[0]};
   endfunction : lvl
   // Write, idle cycle, read of one address
   sequence s_mask_wr_rd;
      reg_wr && reg_addr == pit_pkg::ADDR_MASK_LEVEL ##1 !reg_wr ##1 reg_rd && reg_addr == pit_pkg::ADDR_MASK_LEVEL;
   endsequence
   sequence s_cmp_wr_rd;
      reg_wr && reg_addr == pit_pkg::ADDR_COMPARE_A ##1 !reg_wr ##1 reg_rd && reg_addr == pit_pkg::ADDR_COMPARE_A;
   endsequence
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   AST_MASK_RB: assert property (s_mask_wr_rd |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
      else $error("mask register read back wrong");
   AST_CMP_RB: assert property (s_cmp_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
      else $error("compare register read back wrong");
   AST_MASK_ALL: assert property (reg_wr && reg_addr == pit_pkg::ADDR_MASK_LEVEL && reg_wdata[2:0] == 3'h7
      |-> ##2 !irq_valid)
      else $error("request passed with all levels masked");
   AST_NOT_MASKED: assert property (irq_valid |-> (($past(mask_sh_ff) >> irq_level) & 3'h1) == 3'h0)
      else $error("request at a masked level");
   AST_PIN_LEVEL: assert property (irq_valid && irq_source == pit_pkg::SRC_PIN
      |-> irq_level == lvl($past(pri_a_sh_ff)))
      else $error("pin request level wrong");
   AST_TIMER_LEVEL: assert property (irq_valid && irq_source == pit_pkg::SRC_TIMER
      |-> irq_level == lvl($past(pri_c_sh_ff)))
      else $error("timer request level wrong");
   AST_VALID_HOLD: assert property (irq_valid && !$past(reg_wr) |=> irq_valid && irq_level >= $past(irq_level))
      else $error("request dropped or lowered without a write");
endmodule : pit_link_monitor

// *** test/priority_interrupt_timer_tb.sv ***
// Bench joining device and core ends over the link.
// Assumes 20 MHz clock; drives software port, pin and handler pulses.
`timescale 1ns/100ps
module priority_interrupt_timer_tb;
   logic clk_sys_i = 1'b0; // System clock
   logic reset_n_i = 1'b0; // Reset, active low
   logic [15:0] sw_addr = 16'h0000; // Software address
   logic [15:0] sw_wdata = 16'h0000; // Software write data
   logic sw_wr = 1'b0; // Write strobe
   logic sw_rd = 1'b0; // Read strobe
   logic [15:0] sw_rdata; // Read answer
   logic pin_n = 1'b1; // Request pin, active low
   logic dis_clr = 1'b0; // Clears core disable bit
   logic ret = 1'b0; // Handler return
   logic acc; // Accept pulse
   logic [1:0] acc_lvl; // Accepted level
   logic acc_src; // Accepted source
   logic [2:0] depth; // Nesting depth
   logic dis_bit; // Core disable bit
   logic match; // Compare match pulse
   logic [15:0] got; // Saved read value
   int n_mismatch = 0;
   int checks = 0;
   int n;
   pit_link_if pit_link_if_i ();
   always #25 clk_sys_i = ~clk_sys_i;
   pit_device pit_device_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(pit_link_if_i),
      .external_request_pin_n_i(pin_n), .compare_match_o(match));
   pit_core pit_core_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(pit_link_if_i),
      .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
      .disable_clear_i(dis_clr), .disable_set_i(1'b0), .handler_return_i(ret), .accept_o(acc),
      .accept_level_o(acc_lvl), .accept_source_o(acc_src), .disable_bit_o(dis_bit), .nest_depth_o(depth));
   pit_link_monitor pit_link_monitor_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .reg_addr(pit_link_if_i.reg_addr), .reg_wdata(pit_link_if_i.reg_wdata), .reg_wr(pit_link_if_i.reg_wr),
      .reg_rd(pit_link_if_i.reg_rd), .reg_rdata(pit_link_if_i.reg_rdata), .irq_valid(pit_link_if_i.irq_valid),
      .irq_level(pit_link_if_i.irq_level), .irq_source(pit_link_if_i.irq_source));
   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // One-cycle write
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk_sys_i);
      sw_wr <= 1'b0;
   endtask : wr
   // One-cycle read, answer taken in the next cycle
   task automatic rd(input logic [15:0] a, output logic [15:0] g);
      @(posedge clk_sys_i);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk_sys_i);
      sw_rd <= 1'b0;
      #1 g = sw_rdata;
   endtask : rd
   task automatic rdc(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] g;
      rd(a, g);
      chk(g, e);
   endtask : rdc
   // Handler return (r=1) or disable-bit clear pulse
   task automatic core_pulse(input logic r);
      @(posedge clk_sys_i);
      if (r) ret <= 1'b1;
      else dis_clr <= 1'b1;
      @(posedge clk_sys_i);
      ret <= 1'b0;
      dis_clr <= 1'b0;
   endtask : core_pulse
   // Wait for an acceptance, then check what was taken
   task automatic wait_acc(input logic [1:0] l, input logic s);
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (acc !== 1'b1 && n < 40);
      chk({12'h000, acc, acc_src, acc_lvl}, {13'h0001, s, l});
   endtask : wait_acc
   // Cycles until the next compare match pulse
   task automatic wait_match();
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (match !== 1'b1 && n < 3000);
   endtask : wait_match
   // Verdict and end of run
   task automatic report_and_stop();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rdc(pit_pkg::ADDR_COMPARE_A, 16'hFFFF);
      rdc(pit_pkg::ADDR_MASK_LEVEL, 16'h0000);
      rdc(16'hF000, 16'h0000); // Unmapped place reads zero
      wr(pit_pkg::ADDR_MASK_LEVEL, 16'h12A5);
      rdc(pit_pkg::ADDR_MASK_LEVEL, 16'h00A5);
      wr(pit_pkg::ADDR_COMPARE_A, 16'h0003);
      rdc(pit_pkg::ADDR_COMPARE_A, 16'h0003);
      wr(pit_pkg::ADDR_MASK_LEVEL, 16'h0000);
      wr(pit_pkg::ADDR_REQUEST_ENABLE, 16'h0001);
      // Pin edge ignored while the pin serves as port
      pin_n <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      pin_n <= 1'b1;
      rdc(pit_pkg::ADDR_REQUEST_FLAGS, 16'h0000);
      wr(pit_pkg::ADDR_PIN_FUNCTION, 16'h0001);
      wr(pit_pkg::ADDR_EDGE_SELECT, 16'h0000);
      core_pulse(1'b0);
      #1 chk({15'h0000, dis_bit}, 16'h0000); // Disable bit cleared
      // Every priority field value on the pin, falling edge each time
      for (int p = 3; p >= 0; p--) begin
         wr(pit_pkg::ADDR_PRIORITY_A, 16'(p) << 6);
         pin_n <= 1'b0;
         wait_acc((p > 1) ? 2'h2 : 2'(p), pit_pkg::SRC_PIN);
         @(posedge clk_sys_i);
         pin_n <= 1'b1;
         rdc(pit_pkg::ADDR_REQUEST_FLAGS, 16'h0001);
         wr(pit_pkg::ADDR_REQUEST_FLAGS, 16'h0000);
         rdc(pit_pkg::ADDR_REQUEST_FLAGS, 16'h0000);
         if (p != 0) core_pulse(1'b1);
      end
      // Level-zero handler running: mask level zero, allow nesting
      wr(pit_pkg::ADDR_MASK_LEVEL, 16'h0001);
      core_pulse(1'b0);
      wr(pit_pkg::ADDR_TIMER_CONTROL, 16'h0026);
      wr(pit_pkg::ADDR_OPERATING_MODE, 16'h0000);
      wr(pit_pkg::ADDR_INTERRUPT_ENABLE, 16'h0001);
      wr(pit_pkg::ADDR_TIMER_START, 16'h0002);
      wait_match();
      wait_match();
      chk(16'(n), 16'(4 * 256)); // Match period, clear on match
      chk({12'h000, pit_link_if_i.irq_valid, depth}, 16'h0001); // Timer held back
      rdc(pit_pkg::ADDR_STATUS_FLAGS, 16'h0001);
      wr(pit_pkg::ADDR_PRIORITY_C, 16'h0040);
      wait_acc(2'h1, pit_pkg::SRC_TIMER);
      chk({13'h0000, depth}, 16'h0002);
      chk({15'h0000, dis_bit}, 16'h0001); // Entry sets disable bit again
      wr(pit_pkg::ADDR_MASK_LEVEL, 16'h0007);
      repeat (2) @(posedge clk_sys_i);
      #1 chk({15'h0000, pit_link_if_i.irq_valid}, 16'h0000);
      // Stopped counter holds its value
      wr(pit_pkg::ADDR_TIMER_START, 16'h0000);
      rd(pit_pkg::ADDR_COUNTER, got);
      repeat (600) @(posedge clk_sys_i);
      rdc(pit_pkg::ADDR_COUNTER, got);
      wr(pit_pkg::ADDR_STATUS_FLAGS, 16'h0001);
      rdc(pit_pkg::ADDR_STATUS_FLAGS, 16'h0001);
      wr(pit_pkg::ADDR_STATUS_FLAGS, 16'h0000);
      rdc(pit_pkg::ADDR_STATUS_FLAGS, 16'h0000);
      report_and_stop();
   end
endmodule : priority_interrupt_timer_tb
